// >>> design/capture_fifo.sv
module capture_fifo
  import capture_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS,
  parameter int DEPTH = RECORD_WORDS,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Converter channels, asynchronous to clock_i
  input wire logic channel_a_sample_clock_i,
  input wire logic [WIDTH-1:0] channel_a_sample_bits_i,
  input wire logic channel_b_sample_clock_i,
  input wire logic [WIDTH-1:0] channel_b_sample_bits_i,
  // Host control
  input wire logic fifo_reset_i,
  input wire logic read_clock_i,
  output logic [2*WIDTH-1:0] read_data_o,
  output logic read_valid_o,
  output logic fifo_full_o,
  output logic fifo_empty_o,
  output logic [AW:0] fill_level_o,
  // Serial configuration bus
  input wire logic [TARGET_SEL_BITS-1:0] target_choice_i,
  input wire logic cfg_start_i,
  input wire logic [7:0] cfg_byte_i,
  input wire logic cfg_miso_i,
  output logic cfg_sclk_o,
  output logic cfg_mosi_o,
  output logic [NUM_TARGETS-1:0] config_target_select_n_o,
  output logic [7:0] cfg_rx_byte_o,
  output logic cfg_busy_o
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [WIDTH-1:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
  logic [2:0] ca_q, cb_q, rclk_q, rst_f_q;
  logic cfg_start_s1_q, cfg_start_s2_q, miso_s1_q, miso_s2_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      a_s1_q <= '0;
      a_s2_q <= '0;
      b_s1_q <= '0;
      b_s2_q <= '0;
      ca_q <= '0;
      cb_q <= '0;
      rclk_q <= '0;
      rst_f_q <= '0;
      cfg_start_s1_q <= 1'b0;
      cfg_start_s2_q <= 1'b0;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      a_s1_q <= channel_a_sample_bits_i;
      a_s2_q <= a_s1_q;
      b_s1_q <= channel_b_sample_bits_i;
      b_s2_q <= b_s1_q;
      ca_q <= {ca_q[1:0], channel_a_sample_clock_i};
      cb_q <= {cb_q[1:0], channel_b_sample_clock_i};
      rclk_q <= {rclk_q[1:0], read_clock_i};
      rst_f_q <= {rst_f_q[1:0], fifo_reset_i};
      cfg_start_s1_q <= cfg_start_i;
      cfg_start_s2_q <= cfg_start_s1_q;
      miso_s1_q <= cfg_miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end

  function automatic logic rose(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  // Edge detectors read only bits 1 and 2 (the last two stages) of the 3-deep shift
  wire logic a_edge = rose(ca_q);
  wire logic b_edge = rose(cb_q);
  wire logic rd_edge = rose(rclk_q);
  wire logic flush = rose(rst_f_q);

  // ------------------------------------------------------------
  // Fill control
  // ------------------------------------------------------------
  fill_state_e state_q;
  logic [AW:0] wr_ptr_q, rd_ptr_q;
  logic [WIDTH-1:0] a_hold_q;
  logic a_pend_q;
  logic wr_en;
  wire logic full = (wr_ptr_q - rd_ptr_q) == (AW+1)'(DEPTH);
  wire logic empty = wr_ptr_q == rd_ptr_q;

  // Channel A word waits for the matching channel B edge; pair stored as one word
  assign wr_en = (state_q == FILL_RUN) && b_edge && a_pend_q && !full;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      a_hold_q <= '0;
      a_pend_q <= 1'b0;
    end else if (flush) begin
      a_pend_q <= 1'b0;
    end else if (a_edge) begin
      a_hold_q <= a_s2_q;
      a_pend_q <= 1'b1;
    end else if (wr_en) begin
      a_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= FILL_IDLE;
    end else begin
      case (state_q)
        FILL_IDLE: if (flush) state_q <= FILL_RUN;
        FILL_RUN: begin
          if (flush) state_q <= FILL_RUN;
          else if (full) state_q <= FILL_DONE;
        end
        FILL_DONE: if (flush) state_q <= FILL_RUN;
        default: state_q <= FILL_IDLE;
      endcase
    end
  end

  // Pointers; flush clears the record and restarts filling
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (wr_en) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (rd_edge && !empty) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  logic [2*WIDTH-1:0] ram_q;
  capture_ram #(.WIDTH(2*WIDTH), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .clock_i(clock_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_ptr_q[AW-1:0]),
    .wr_data_i({a_hold_q, b_s2_q}),
    .rd_addr_i(rd_ptr_q[AW-1:0]),
    .rd_data_o(ram_q)
  );

  // ------------------------------------------------------------
  // Read-back and status
  // ------------------------------------------------------------
  logic rd_take_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_take_q <= 1'b0;
      read_data_o <= '0;
      read_valid_o <= 1'b0;
      fifo_full_o <= 1'b0;
      fifo_empty_o <= 1'b1;
      fill_level_o <= '0;
    end else begin
      rd_take_q <= rd_edge && !empty && !flush;
      read_valid_o <= rd_take_q;
      if (rd_take_q) read_data_o <= ram_q;
      fifo_full_o <= full;
      fifo_empty_o <= empty;
      fill_level_o <= wr_ptr_q - rd_ptr_q;
    end
  end

  // ------------------------------------------------------------
  // Serial configuration master
  // ------------------------------------------------------------
  // Mode 0, sclk = clock_i/2; shared clock and data for all targets
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic phase_q, start_d_q;

  function automatic logic [NUM_TARGETS-1:0] sel_decode(input logic [TARGET_SEL_BITS-1:0] t);
    logic [NUM_TARGETS-1:0] m;
    m = '1;
    if (int'(t) < NUM_TARGETS) m[t] = 1'b0;
    else m[DEFAULT_TARGET] = 1'b0;
    return m;
  endfunction

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_d_q <= 1'b0;
      cfg_busy_o <= 1'b0;
      bit_cnt_q <= '0;
      sh_q <= '0;
      phase_q <= 1'b0;
      cfg_sclk_o <= 1'b0;
      cfg_mosi_o <= 1'b0;
      cfg_rx_byte_o <= '0;
      config_target_select_n_o <= '1;
    end else begin
      start_d_q <= cfg_start_s2_q;
      if (!cfg_busy_o) begin
        cfg_sclk_o <= 1'b0;
        if (cfg_start_s2_q && !start_d_q) begin
          cfg_busy_o <= 1'b1;
          config_target_select_n_o <= sel_decode(target_choice_i);
          sh_q <= cfg_byte_i;
          cfg_mosi_o <= cfg_byte_i[7];
          bit_cnt_q <= 4'h8;
          phase_q <= 1'b0;
        end
      end else if (bit_cnt_q == 4'h0) begin
        cfg_busy_o <= 1'b0;
        config_target_select_n_o <= '1;
        // Synchronised data in lags one sclk period: first shift is stale, last bit taken here
        cfg_rx_byte_o <= {sh_q[6:0], miso_s2_q};
      end else begin
        phase_q <= ~phase_q;
        cfg_sclk_o <= ~phase_q;
        if (!phase_q) begin
          sh_q <= {sh_q[6:0], miso_s2_q};
        end else begin
          cfg_mosi_o <= sh_q[7];
          bit_cnt_q <= bit_cnt_q - 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_flush;
    flush;
  endsequence
  sequence s_cleared;
    ##1 (wr_ptr_q == '0 && rd_ptr_q == '0 && state_q == FILL_RUN);
  endsequence

  a_flush_clears: assert property (@(posedge clock_i) disable iff (rst_i)
    s_flush |-> s_cleared) else $error("fifo reset did not clear record");
  a_one_select: assert property (@(posedge clock_i) disable iff (rst_i)
    cfg_busy_o |-> $onehot(~config_target_select_n_o)) else $error("select not one-hot");
  a_default_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    (cfg_start_s2_q && !start_d_q && !cfg_busy_o && int'(target_choice_i) >= NUM_TARGETS)
    |=> !config_target_select_n_o[DEFAULT_TARGET]) else $error("default select not used");
  a_idle_deselect: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg_busy_o |-> config_target_select_n_o == '1) else $error("select low while idle");
  a_full_holds: assert property (@(posedge clock_i) disable iff (rst_i)
    (full && !flush) |=> (wr_ptr_q == $past(wr_ptr_q))) else $error("write past full");
  a_depth_cap: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_ptr_q - rd_ptr_q) <= (AW+1)'(DEPTH)) else $error("fill exceeds depth");
  a_write_pair: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_en |-> (b_edge && a_pend_q)) else $error("write without channel clocks");
  a_read_valid: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_edge && !empty && !flush) |-> ##2 read_valid_o) else $error("read data missing");
  a_sclk_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg_busy_o |=> !cfg_sclk_o || cfg_busy_o) else $error("serial clock runs idle");
endmodule // capture_fifo

// >>> design/capture_pkg.sv
// Summary of operation
// - Bridge drives four-wire serial config bus: clock, data in, data out, select.
// - Config master addresses up to five targets, the capture logic among them.
// - Serial clock and data lines are shared by every target.
// - Exactly one active-low select goes low per transfer, chosen by host.
// - Select line zero is the default when no other target is chosen.
// - Capture starts with a host FIFO reset that clears contents and restarts fill.
// - Captured samples are read out through the USB side on the restored clock.
// - Each channel registers sample words on its own board-supplied data clock.
// - Two parallel channels, each up to 18 bits wide.
// - FIFO holds a record of up to 64 kB in total.
package capture_pkg;
  localparam int SAMPLE_BITS = 18;
  localparam int RECORD_BYTES = 65536;
  localparam int WORD_BYTES = 8;
  localparam int RECORD_WORDS = RECORD_BYTES / WORD_BYTES;
  localparam int NUM_TARGETS = 5;
  localparam int DEFAULT_TARGET = 0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TARGET_SEL_BITS = 3;
  localparam logic [TARGET_SEL_BITS-1:0] TARGET_NONE = 3'h7;
  localparam int CAPTURE_WAIT_NS = 30000000;
  localparam int CAPTURE_WAIT_CYCLES = CAPTURE_WAIT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FILL_IDLE,
    FILL_RUN,
    FILL_DONE
  } fill_state_e;
endpackage

// >>> design/capture_ram.sv
module capture_ram #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8192,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clock_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read keeps the block-RAM style timing
  always_ff @(posedge clock_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // capture_ram

// >>> bench/capture_partner.sv
module capture_partner (
  // Converter channels
  output logic channel_a_sample_clock_o,
  output logic [17:0] channel_a_sample_bits_o,
  output logic channel_b_sample_clock_o,
  output logic [17:0] channel_b_sample_bits_o,
  // Serial target
  input wire logic cfg_sclk_i,
  input wire logic [4:0] select_n_i,
  output logic cfg_miso_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] reply = 8'h00;
  int bit_idx = 0;
  initial begin
    channel_a_sample_clock_o = 1'b0;
    channel_b_sample_clock_o = 1'b0;
    channel_a_sample_bits_o = 18'h00000;
    channel_b_sample_bits_o = 18'h3ffff;
    cfg_miso_o = 1'b1;
  end
  // ----------------
  // Capture traffic
  // ----------------
  // Clocks only run inside a word, A strictly before B
  task automatic send_word(input logic [17:0] a, input logic [17:0] b);
    channel_a_sample_bits_o = a;
    #40 channel_a_sample_clock_o = 1'b1;
    #40 channel_a_sample_clock_o = 1'b0;
    channel_b_sample_bits_o = b;
    #40 channel_b_sample_clock_o = 1'b1;
    #40 channel_b_sample_clock_o = 1'b0;
    #40 channel_a_sample_bits_o = ~a;
    channel_b_sample_bits_o = ~b;
  endtask
  // ----------------
  // Serial target
  // ----------------
  always @(negedge (&select_n_i)) begin
    bit_idx = 7;
    cfg_miso_o = reply[7];
  end
  always @(negedge cfg_sclk_i) begin
    if (!(&select_n_i) && bit_idx > 0) begin
      bit_idx--;
      cfg_miso_o = reply[bit_idx];
    end
  end
  // Released line must not keep the last bit
  always @(posedge (&select_n_i)) cfg_miso_o = ~cfg_miso_o;
endmodule // capture_partner

// >>> bench/adc_capture_fifo_spi_select_test.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t got %h expected %h", $time, g, e); end end
module adc_capture_fifo_spi_select_test
  import capture_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 16;
  // Host capture wait, shortened to keep the run brief
  localparam int FILL_WAIT_CYCLES = 40;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ca_clk, cb_clk, miso, fifo_reset_i, read_clock_i, read_valid_o, fifo_full_o;
  logic fifo_empty_o, cfg_start_i, cfg_sclk_o, cfg_mosi_o, cfg_busy_o;
  logic [17:0] ca_bits, cb_bits, a, b;
  logic [35:0] read_data_o;
  logic [4:0] fill_level_o, config_target_select_n_o;
  logic [2:0] target_choice_i;
  logic [7:0] cfg_byte_i, cfg_rx_byte_o;
  logic [35:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int seed;
  always #5 clock_i = ~clock_i;
  capture_fifo #(.DEPTH(DEPTH)) i_capture_fifo (.clock_i(clock_i), .rst_i(rst_i),
    .channel_a_sample_clock_i(ca_clk), .channel_a_sample_bits_i(ca_bits),
    .channel_b_sample_clock_i(cb_clk), .channel_b_sample_bits_i(cb_bits),
    .fifo_reset_i(fifo_reset_i), .read_clock_i(read_clock_i), .read_data_o(read_data_o),
    .read_valid_o(read_valid_o), .fifo_full_o(fifo_full_o), .fifo_empty_o(fifo_empty_o),
    .fill_level_o(fill_level_o), .target_choice_i(target_choice_i),
    .cfg_start_i(cfg_start_i), .cfg_byte_i(cfg_byte_i), .cfg_miso_i(miso),
    .cfg_sclk_o(cfg_sclk_o), .cfg_mosi_o(cfg_mosi_o),
    .config_target_select_n_o(config_target_select_n_o), .cfg_rx_byte_o(cfg_rx_byte_o),
    .cfg_busy_o(cfg_busy_o));
  capture_partner i_capture_partner (.channel_a_sample_clock_o(ca_clk),
    .channel_a_sample_bits_o(ca_bits), .channel_b_sample_clock_o(cb_clk),
    .channel_b_sample_bits_o(cb_bits), .cfg_sclk_i(cfg_sclk_o),
    .select_n_i(config_target_select_n_o), .cfg_miso_o(miso));
  // ----------------
  // Host tasks
  // ----------------
  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic fifo_flush();
    @(posedge clock_i) #1 fifo_reset_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 fifo_reset_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #1 exp_q.delete();
    `CHK(fill_level_o, 5'h00)
    `CHK(fifo_empty_o, 1'b1)
  endtask
  task automatic read_word();
    int n;
    logic [35:0] e;
    e = exp_q.pop_front();
    // 80 ns read clock: high for four system cycles, low for four
    read_clock_i = 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
      if (n == 4) read_clock_i = 1'b0;
    end while (read_valid_o !== 1'b1 && n < 12);
    `CHK(read_valid_o, 1'b1)
    `CHK(read_data_o, e)
    while (n < 8) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
  task automatic cfg_xfer(input int tgt, input logic [7:0] tx, input logic [7:0] back);
    int n;
    logic [7:0] got;
    logic [4:0] sel;
    sel = ~(5'h01 << ((tgt < NUM_TARGETS) ? tgt : DEFAULT_TARGET));
    i_capture_partner.reply = back;
    @(posedge clock_i) #1;
    target_choice_i = 3'(tgt);
    cfg_byte_i = tx;
    cfg_start_i = 1'b1;
    n = 0;
    do begin @(posedge clock_i); #1; n++; end while (cfg_busy_o !== 1'b1 && n < 20);
    `CHK(cfg_busy_o, 1'b1)
    cfg_start_i = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge cfg_sclk_o) got[i] = cfg_mosi_o;
      `CHK(config_target_select_n_o, sel)
    end
    n = 0;
    do begin @(posedge clock_i); #1; n++; end while (cfg_busy_o !== 1'b0 && n < 40);
    @(posedge clock_i) #1;
    `CHK(got, tx)
    `CHK(cfg_rx_byte_o, back)
    `CHK(cfg_busy_o, 1'b0)
    `CHK(config_target_select_n_o, 5'h1f)
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    seed = 32'he81cb5af;
    fifo_reset_i = 1'b0;
    read_clock_i = 1'b0;
    target_choice_i = 3'h0;
    cfg_start_i = 1'b0;
    cfg_byte_i = 8'h00;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    `CHK(config_target_select_n_o, 5'h1f)
    `CHK(fifo_empty_o, 1'b1)
    // Host identifies the converter, then loads the capture setup
    cfg_xfer(DEFAULT_TARGET, 8'($random(seed)), 8'($random(seed)));
    cfg_xfer(1, 8'($random(seed)), 8'($random(seed)));
    // No fill before the first flush
    i_capture_partner.send_word(18'h2aaaa, 18'h15555);
    `CHK(fill_level_o, 5'h00)
    for (int pass = 0; pass < 2; pass++) begin
      fifo_flush();
      read_clock_i = 1'b0; // Read clock stays stopped while filling
      for (int k = 0; k < DEPTH + 2; k++) begin
        a = 18'($random(seed));
        b = 18'($random(seed));
        i_capture_partner.send_word(a, b);
        if (exp_q.size() < DEPTH) exp_q.push_back({a, b});
        `CHK(fill_level_o, 5'(exp_q.size()))
      end
      `CHK(fifo_full_o, 1'b1)
      repeat (FILL_WAIT_CYCLES) @(posedge clock_i); // Host waits before reading
      #1;
      repeat (pass ? DEPTH : DEPTH / 2) read_word();
      `CHK(fill_level_o, 5'(exp_q.size()))
      `CHK(fifo_empty_o, 1'(pass))
      `CHK(fifo_full_o, 1'b0)
    end
    for (int t = 0; t < 8; t++) begin
      cfg_xfer(t, 8'($random(seed)), 8'($random(seed)));
    end
    summarize();
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule // adc_capture_fifo_spi_select_test
